// [pkg/sss_cfg.svh]
`ifndef SSS_CFG_SVH
`define SSS_CFG_SVH

// ************************************************************
// register offsets
// ************************************************************
`define SSS_ADDR_W          4
`define SSS_OFF_CTL_FIRST   4'h0
`define SSS_OFF_CTL_SECOND  4'h1
`define SSS_OFF_STATUS      4'h2
`define SSS_OFF_WAKE_EN     4'h3
`define SSS_OFF_RESULT      4'h4
`define SSS_OFF_STATE       4'h5

// ************************************************************
// fields
// ************************************************************
`define SSS_TYP_LSB         10
`define SSS_TYP_MSB         12
`define SSS_GO_BIT          13
`define SSS_WAKE_FLAG_BIT   15
`define SSS_RES_NO_POWER    32'h0000_0001
`define SSS_RES_THERMAL     32'h0000_0002

// ************************************************************
// sleep type codes and timing
// ************************************************************
`define SSS_TYP_S0          3'h0
`define SSS_TYP_S3          3'h3
`define SSS_TYP_S4          3'h4
`define SSS_TYP_S5          3'h5
`define SSS_SETTLE_NS       1000
`define SSS_CLK_NS          25
`define SSS_SETTLE_CYC      ((`SSS_SETTLE_NS + `SSS_CLK_NS - 1) / `SSS_CLK_NS)

`endif

// [pkg/sss_pkg.sv]
package sss_pkg;
    typedef enum logic [1:0] {
        SSS_ST_WORK,
        SSS_ST_ENTER,
        SSS_ST_SLEEP,
        SSS_ST_WAKE
    } sss_state_e;

    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } sss_bus_s;

    typedef struct packed {
        logic       dram_retain;
        logic       cpu_run;
        logic [3:0] res_off;
        logic       dev_d3;
        logic       cold_boot;
        logic       resume_boot;
    } sss_pwr_s;
endpackage : sss_pkg

// [core/sss_seq.sv]
// The address map and the plain strobed port were left to the implementer.
`include "sss_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module sss_seq #(
    parameter int SETTLE_CYC = `SSS_SETTLE_CYC,
    parameter int N_WAKE     = 8
) (
    // clock and reset
    input  wire logic                clk_sys,
    input  wire logic                rst_b,
    // register port
    input  wire logic [3:0]          reg_addr,
    input  wire logic [31:0]         reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic      [31:0]         reg_rdata,
    // wake sources and status pins
    input  wire logic [N_WAKE-1:0]   wake_src,
    input  wire logic                supply_short,
    input  wire logic                thermal_trip,
    // power controls
    output logic                     dram_retain,
    output logic                     cpu_run,
    output logic      [3:0]          res_off,
    output logic                     dev_d3,
    output logic                     cold_boot,
    output logic                     resume_boot
);

    default clocking chk_cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    // ************************************************************
    // input synchronisers
    // ************************************************************
    logic [N_WAKE+1:0] sync1_r, sync2_r;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= {thermal_trip, supply_short, wake_src};
            sync2_r <= sync1_r;
        end
    end
    logic [N_WAKE-1:0] wake_s;
    logic              short_s, therm_s;
    assign wake_s  = sync2_r[N_WAKE-1:0];
    assign short_s = sync2_r[N_WAKE];
    assign therm_s = sync2_r[N_WAKE+1];

    // ************************************************************
    // state
    // ************************************************************
    sss_pkg::sss_state_e st_r, st_nxt;
    logic [2:0]        typ1_r, typ1_nxt, typ2_r, typ2_nxt;
    logic [2:0]        cur_r, cur_nxt, ended_r, ended_nxt;
    logic [2:0]        pss_r, pss_nxt;
    logic [1:0]        res_r, res_nxt;
    logic              wflag_r, wflag_nxt;
    logic [N_WAKE-1:0] wen_r, wen_nxt;
    logic [15:0]       cnt_r, cnt_nxt;
    logic              cold_r, cold_nxt, resm_r, resm_nxt;

    function automatic logic [3:0] off_mask(input logic [2:0] t);
        // one bit per power resource level S0..S3
        unique case (t)
            `SSS_TYP_S3: off_mask = 4'h7;
            `SSS_TYP_S4: off_mask = 4'hf;
            `SSS_TYP_S5: off_mask = 4'hf;
            default:     off_mask = 4'h0;
        endcase
    endfunction : off_mask

    logic go_wr, wake_hit;
    assign go_wr = reg_wr && reg_wdata[`SSS_GO_BIT]
                   && (reg_addr == `SSS_OFF_CTL_SECOND);
    // wakes count only from sources enabled in wen_r, whatever the sleep type
    assign wake_hit = |(wake_s & wen_r);

    always_comb begin
        st_nxt    = st_r;
        typ1_nxt  = typ1_r;
        typ2_nxt  = typ2_r;
        cur_nxt   = cur_r;
        ended_nxt = ended_r;
        pss_nxt   = pss_r;
        res_nxt   = res_r;
        wflag_nxt = wflag_r;
        wen_nxt   = wen_r;
        cnt_nxt   = cnt_r;
        cold_nxt  = 1'b0;
        resm_nxt  = 1'b0;
        if (reg_wr && reg_addr == `SSS_OFF_CTL_FIRST)
            typ1_nxt = reg_wdata[`SSS_TYP_MSB:`SSS_TYP_LSB];
        if (reg_wr && reg_addr == `SSS_OFF_CTL_SECOND)
            typ2_nxt = reg_wdata[`SSS_TYP_MSB:`SSS_TYP_LSB];
        if (reg_wr && reg_addr == `SSS_OFF_WAKE_EN)
            wen_nxt = reg_wdata[N_WAKE-1:0];
        if (reg_wr && reg_addr == `SSS_OFF_STATUS
            && reg_wdata[`SSS_WAKE_FLAG_BIT])
            wflag_nxt = 1'b0;
        unique case (st_r)
            sss_pkg::SSS_ST_WORK: begin
                if (go_wr) begin
                    // type taken from this very write
                    cur_nxt = reg_wdata[`SSS_TYP_MSB:`SSS_TYP_LSB];
                    cnt_nxt = 16'(SETTLE_CYC);
                    res_nxt = 2'b00;
                    st_nxt  = sss_pkg::SSS_ST_ENTER;
                end
            end
            sss_pkg::SSS_ST_ENTER: begin
                if (cnt_r != 16'h0000) begin
                    cnt_nxt = cnt_r - 16'h0001;
                end else begin
                    // excess current leaves us one level short
                    pss_nxt = short_s ? cur_r - 3'h1 : cur_r;
                    st_nxt  = sss_pkg::SSS_ST_SLEEP;
                end
            end
            sss_pkg::SSS_ST_SLEEP: begin
                if (wake_hit) begin
                    if (short_s)
                        res_nxt = 2'b01;
                    else if (therm_s)
                        res_nxt = 2'b10;
                    else begin
                        cnt_nxt = 16'(SETTLE_CYC);
                        st_nxt  = sss_pkg::SSS_ST_WAKE;
                    end
                end
            end
            sss_pkg::SSS_ST_WAKE: begin
                if (cnt_r != 16'h0000) begin
                    cnt_nxt = cnt_r - 16'h0001;
                end else begin
                    ended_nxt = cur_r;
                    cold_nxt  = (cur_r != `SSS_TYP_S3);
                    resm_nxt  = (cur_r == `SSS_TYP_S3);
                    wflag_nxt = 1'b1;
                    cur_nxt   = `SSS_TYP_S0;
                    st_nxt    = sss_pkg::SSS_ST_WORK;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st_r    <= sss_pkg::SSS_ST_WORK;
            typ1_r  <= 3'h0;
            typ2_r  <= 3'h0;
            cur_r   <= 3'h0;
            ended_r <= 3'h0;
            pss_r   <= 3'h0;
            res_r   <= 2'b00;
            wflag_r <= 1'b0;
            wen_r   <= '0;
            cnt_r   <= 16'h0000;
            cold_r  <= 1'b0;
            resm_r  <= 1'b0;
        end else begin
            st_r    <= st_nxt;
            typ1_r  <= typ1_nxt;
            typ2_r  <= typ2_nxt;
            cur_r   <= cur_nxt;
            ended_r <= ended_nxt;
            pss_r   <= pss_nxt;
            res_r   <= res_nxt;
            wflag_r <= wflag_nxt;
            wen_r   <= wen_nxt;
            cnt_r   <= cnt_nxt;
            cold_r  <= cold_nxt;
            resm_r  <= resm_nxt;
        end
    end

    // ************************************************************
    // power outputs
    // ************************************************************
    logic asleep;
    assign asleep      = (st_r != sss_pkg::SSS_ST_WORK);
    assign cpu_run     = !asleep;
    assign dram_retain = asleep && (cur_r == `SSS_TYP_S3);
    assign res_off     = asleep ? off_mask(cur_r) : 4'h0;
    assign dev_d3      = asleep && (cur_r != `SSS_TYP_S3);
    assign cold_boot   = cold_r;
    assign resume_boot = resm_r;

    // ************************************************************
    // read path
    // ************************************************************
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `SSS_OFF_CTL_FIRST:
                    reg_rdata <= 32'({typ1_r, {`SSS_TYP_LSB{1'b0}}});
                `SSS_OFF_CTL_SECOND:
                    reg_rdata <= 32'({typ2_r, {`SSS_TYP_LSB{1'b0}}});
                `SSS_OFF_STATUS:
                    reg_rdata <= 32'({wflag_r, {`SSS_WAKE_FLAG_BIT{1'b0}}});
                `SSS_OFF_WAKE_EN:
                    reg_rdata <= 32'(wen_r);
                `SSS_OFF_RESULT:
                    reg_rdata <= 32'({pss_r, 6'h00, res_r});
                `SSS_OFF_STATE:
                    reg_rdata <= 32'(ended_r);
                default:
                    reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    logic [2:0] wr_typ;
    assign wr_typ = reg_wdata[`SSS_TYP_MSB:`SSS_TYP_LSB];

    sequence go_seq;
        go_wr && st_r == sss_pkg::SSS_ST_WORK;
    endsequence

    sequence settle_done_seq;
        st_r == sss_pkg::SSS_ST_ENTER && cnt_r == 16'h0000;
    endsequence

    sequence wake_ok_seq;
        st_r == sss_pkg::SSS_ST_SLEEP && wake_hit && !short_s && !therm_s;
    endsequence

    sequence wake_fail_seq;
        st_r == sss_pkg::SSS_ST_SLEEP && wake_hit && (short_s || therm_s);
    endsequence

    sequence exit_seq;
        st_r == sss_pkg::SSS_ST_WAKE && cnt_r == 16'h0000;
    endsequence

    start_enter_a: assert property (
        go_seq |=> st_r == sss_pkg::SSS_ST_ENTER && cur_r == $past(wr_typ))
        else $error("go write did not start entry");

    go_halt_a: assert property (
        go_seq |=> !cpu_run)
        else $error("cpu still runs after go");

    refuse_go_a: assert property (
        go_wr && st_r == sss_pkg::SSS_ST_SLEEP |=> cur_r == $past(cur_r))
        else $error("go write accepted while asleep");

    s4_direct_a: assert property (
        go_seq ##0 (wr_typ == `SSS_TYP_S4) |=> cur_r == `SSS_TYP_S4
        && st_r == sss_pkg::SSS_ST_ENTER)
        else $error("direct s4 entry refused");

    pss_short_a: assert property (
        settle_done_seq ##0 short_s |=> pss_r == cur_r - 3'h1)
        else $error("supply state not one level short");

    pss_full_a: assert property (
        settle_done_seq ##0 !short_s |=> pss_r == cur_r)
        else $error("supply state not the requested one");

    run_only_work_a: assert property (
        cpu_run |-> st_r == sss_pkg::SSS_ST_WORK && res_off == 4'h0
        && !dev_d3 && !dram_retain)
        else $error("cpu runs while asleep");

    s3_retain_a: assert property (
        asleep && cur_r == `SSS_TYP_S3 |-> dram_retain && !dev_d3
        && res_off == 4'h7)
        else $error("s3 power wrong");

    no_retain_a: assert property (
        dram_retain |-> asleep && cur_r == `SSS_TYP_S3)
        else $error("dram kept outside s3");

    s4_off_a: assert property (
        asleep && cur_r == `SSS_TYP_S4 |-> !dram_retain && dev_d3
        && res_off == 4'hf)
        else $error("s4 power wrong");

    s5_off_a: assert property (
        asleep && cur_r == `SSS_TYP_S5 |-> !dram_retain && dev_d3
        && res_off == 4'hf)
        else $error("s5 power wrong");

    wake_go_a: assert property (
        wake_ok_seq |=> st_r == sss_pkg::SSS_ST_WAKE
        && cnt_r == 16'(SETTLE_CYC))
        else $error("enabled wake ignored");

    stay_asleep_a: assert property (
        wake_fail_seq |=> st_r == sss_pkg::SSS_ST_SLEEP && !cpu_run)
        else $error("failed wake left sleep");

    power_fail_a: assert property (
        wake_fail_seq ##0 short_s |=> res_r == 2'b01)
        else $error("power fail not reported");

    thermal_fail_a: assert property (
        wake_fail_seq ##0 !short_s |=> res_r == 2'b10)
        else $error("thermal fail not reported");

    result_rsvd_a: assert property (
        reg_rd && reg_addr == `SSS_OFF_RESULT |=> reg_rdata[31:11] == 21'h0
        && reg_rdata[7:2] == 6'h00)
        else $error("reserved result bits set");

    wake_flag_a: assert property (
        exit_seq |=> wflag_r && cpu_run)
        else $error("wake flag not set");

    ended_state_a: assert property (
        exit_seq |=> ended_r == $past(cur_r))
        else $error("ended state not reported");

    s3_resume_a: assert property (
        exit_seq ##0 (cur_r == `SSS_TYP_S3) |=> resume_boot && !cold_boot
        && ended_r == 3'h3)
        else $error("s3 exit not resume");

    s5_cold_a: assert property (
        exit_seq ##0 (cur_r == `SSS_TYP_S5) |=> cold_boot && !resume_boot
        && ended_r == 3'h5)
        else $error("s5 exit not cold");

    s4_cold_a: assert property (
        exit_seq ##0 (cur_r == `SSS_TYP_S4) |=> cold_boot && !resume_boot
        && ended_r == 3'h4)
        else $error("s4 exit not cold");

    // set wins: a clear in the exit cycle is lost on purpose
    flag_clear_a: assert property (
        reg_wr && reg_addr == `SSS_OFF_STATUS
        && reg_wdata[`SSS_WAKE_FLAG_BIT]
        && !(st_r == sss_pkg::SSS_ST_WAKE && cnt_r == 16'h0000)
        |=> !wflag_r)
        else $error("wake flag not cleared");

    boot_pulse_a: assert property (
        cold_boot || resume_boot |=> !cold_boot && !resume_boot)
        else $error("boot pulse longer than one cycle");
endmodule : sss_seq
`default_nettype wire

// [testbench/sss_far_model.sv]
`timescale 1ns/1ps
`default_nettype none
module sss_far_model (
    // clock
    input  wire logic       clk_sys,
    // requests from the bench
    input  wire logic [7:0] wake_on,
    input  wire logic       short_on,
    input  wire logic       hot_on,
    // lines into the sequencer
    output logic      [7:0] wake_src,
    output logic            supply_short,
    output logic            thermal_trip
);
    // registered: real sources never move on the sampling edge
    always_ff @(posedge clk_sys) begin
        wake_src     <= wake_on;
        supply_short <= short_on;
        thermal_trip <= hot_on;
    end
endmodule : sss_far_model
`default_nettype wire

// [testbench/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
    typedef struct packed {
        logic [2:0] typ;
        logic       dram;
        logic [3:0] off;
        logic       d3;
        logic       res;
        logic       cold;
    } sss_row_s;
    logic        clk_sys = 1'b0;
    logic        rst_b = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [7:0]  wake_src;
    logic        supply_short;
    logic        thermal_trip;
    logic [7:0]  wake_on = 8'h00;
    logic        short_on = 1'b0;
    logic        hot_on = 1'b0;
    logic        dram_retain, cpu_run, dev_d3, cold_boot, resume_boot;
    logic [3:0]  res_off;
    int          num_errors = 0;
    int          cmp_count = 0;
    int          n_res = 0;
    int          n_cold = 0;
    int          r0, c0;
    sss_row_s    rows [2] = '{'{3'h3, 1'b1, 4'h7, 1'b0, 1'b1, 1'b0},
                              '{3'h4, 1'b0, 4'hf, 1'b1, 1'b0, 1'b1}};

    sss_seq #(.SETTLE_CYC(2), .N_WAKE(8)) sss_seq_inst (
        .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .wake_src(wake_src),
        .supply_short(supply_short), .thermal_trip(thermal_trip),
        .dram_retain(dram_retain), .cpu_run(cpu_run), .res_off(res_off),
        .dev_d3(dev_d3), .cold_boot(cold_boot), .resume_boot(resume_boot));
    sss_far_model sss_far_model_inst (
        .clk_sys(clk_sys), .wake_on(wake_on), .short_on(short_on),
        .hot_on(hot_on), .wake_src(wake_src),
        .supply_short(supply_short), .thermal_trip(thermal_trip));

    always #12.5 clk_sys = ~clk_sys;
    // boot pulses are one cycle long, so count them rather than poll
    always @(posedge clk_sys) begin
        if (resume_boot === 1'b1) n_res++;
        if (cold_boot === 1'b1) n_cold++;
    end

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic chk(input string nm, input logic [31:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rdchk(input string nm, input logic [3:0] a,
                         input logic [31:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk(nm, reg_rdata, e);
    endtask : rdchk
    task automatic go(input logic [2:0] t);
        // caches already flushed
        // memory image already saved
        wr(4'h0, {19'h0, t, 10'h0});
        wr(4'h1, {18'h0, 1'b1, t, 10'h0});
        repeat (6) @(posedge clk_sys);
        #1;
    endtask : go
    task automatic wake_wait;
        for (int i = 0; i < 40 && cpu_run !== 1'b1; i++) @(posedge clk_sys);
        repeat (2) @(posedge clk_sys);
        #1 chk("cpu_run", cpu_run, 32'h1);
    endtask : wake_wait
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : complete_run

    // ************************************************************
    // sequence
    // ************************************************************
    initial begin
        repeat (4) @(posedge clk_sys);
        rst_b <= 1'b1;
        #1 chk("cpu_run", cpu_run, 32'h1);
        $display("reset test done");
        wr(4'h3, 32'h1);
        foreach (rows[i]) begin
            r0 = n_res;
            c0 = n_cold;
            wr(4'h2, 32'h8000);
            go(rows[i].typ);
            chk("cpu_run", cpu_run, 32'h0);
            chk("dram_retain", dram_retain, rows[i].dram);
            chk("res_off", res_off, rows[i].off);
            chk("dev_d3", dev_d3, rows[i].d3);
            @(posedge clk_sys) wake_on <= 8'h01;
            wake_wait();
            @(posedge clk_sys) wake_on <= 8'h00;
            chk("resume", n_res - r0, rows[i].res);
            chk("cold", n_cold - c0, rows[i].cold);
            rdchk("wake_flag", 4'h2, 32'h8000);
            rdchk("ended", 4'h5, rows[i].typ);
            wr(4'h2, 32'h8000);
            rdchk("flag_clear", 4'h2, 32'h0);
            $display("row %0d done", i);
        end
        @(posedge clk_sys) short_on <= 1'b1;
        go(3'h3);
        rdchk("supply_state", 4'h4, 32'h200);
        @(posedge clk_sys) wake_on <= 8'h01;
        repeat (12) @(posedge clk_sys);
        #1 chk("cpu_run", cpu_run, 32'h0);
        rdchk("no_power", 4'h4, 32'h201);
        @(posedge clk_sys) short_on <= 1'b0;
        hot_on <= 1'b1;
        repeat (12) @(posedge clk_sys);
        #1 chk("cpu_run", cpu_run, 32'h0);
        rdchk("result", 4'h4, 32'h202);
        rdchk("unmapped", 4'h7, 32'h0);
        @(posedge clk_sys) hot_on <= 1'b0;
        wake_on <= 8'h00;
        repeat (4) @(posedge clk_sys);
        wake_on <= 8'h01;
        wake_wait();
        @(posedge clk_sys) wake_on <= 8'h00;
        $display("failed wake done");
        wr(4'h3, 32'h0);
        wr(4'h2, 32'h8000);
        go(3'h5);
        chk("res_off", res_off, 32'hf);
        chk("dev_d3", dev_d3, 32'h1);
        rdchk("s5_code", 4'h1, 32'h1400);
        wr(4'h1, 32'h2c00);
        repeat (4) @(posedge clk_sys);
        #1 chk("dram_retain", dram_retain, 32'h0);
        @(posedge clk_sys) wake_on <= 8'h01;
        repeat (12) @(posedge clk_sys);
        #1 chk("cpu_run", cpu_run, 32'h0);
        c0 = n_cold;
        r0 = n_res;
        wr(4'h3, 32'h1);
        wake_wait();
        @(posedge clk_sys) wake_on <= 8'h00;
        chk("cold", n_cold - c0, 32'h1);
        chk("resume", n_res - r0, 32'h0);
        rdchk("ended", 4'h5, 32'h5);
        wr(4'h2, 32'h8000);
        go(3'h4);
        @(posedge clk_sys) rst_b <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rst_b <= 1'b1;
        #1 chk("cpu_run", cpu_run, 32'h1);
        chk("res_off", res_off, 32'h0);
        chk("dev_d3", dev_d3, 32'h0);
        rdchk("ended", 4'h5, 32'h0);
        rdchk("wake_en", 4'h3, 32'h0);
        $display("soft off and reset done");
        complete_run();
    end

    initial begin
        repeat (4000) @(posedge clk_sys);
        num_errors++;
        complete_run();
    end
endmodule : tb
`default_nettype wire
